// ==== scg_regs.vh ====
`ifndef SCG_REGS_VH
`define SCG_REGS_VH
`define SCG_OFF_GEN_CTRL1 8'h00
`define SCG_OFF_DIV_CTRL 8'h04
`define SCG_OFF_CLK_CFG2 8'h08
`define SCG_OFF_PERIPH_GATE1 8'h0c
`define SCG_OFF_IDLE_CFG 8'h10
`define SCG_OFF_STATUS 8'h14
`define SCG_BIT_PWRDN 0
`define SCG_MULT_LSB 16
`define SCG_MULT_MSB 27
`define SCG_RDR_LSB 0
`define SCG_RDR_MSB 11
`define SCG_BIT_RDSKIP 12
`define SCG_ODR_LSB 16
`define SCG_ODR_MSB 22
`define SCG_BIT_ODON 23
`define SCG_BIT_PATHSEL 0
`define SCG_BIT_MSTOP 0
`define SCG_BIT_CPUGATE 0
`define SCG_RST_PWRDN 1'b1
`define SCG_RST_PATHSEL 1'b0
`define SCG_RST_MULT 12'h000
`define SCG_RST_RDR 12'h000
`define SCG_RST_ODR 7'h00
`define SCG_MULT_OFFSET 13'h0004
`define SCG_RDR_OFFSET 13'h0004
`define SCG_LOCK_PERIODS 4
`endif

// ==== scg_dpll.v ====
`timescale 1ns/10ps
module scg_dpll #(
	parameter PW = 16,
	parameter MW = 12,
	parameter LOCK_PERIODS = 4
) (
	input wire clk_in,
	input wire rst_b_in,
	input wire ce_in,
	input wire power_down_in,
	input wire ref_tick_in,
	input wire [MW-1:0] mult_in,
	output reg tick_out,
	output reg locked_out
);
	localparam [MW:0] MULT_OFFSET = 4;
	reg [PW-1:0] cnt;
	reg [PW-1:0] period;
	reg [PW+1:0] acc;
	reg [3:0] stable;
	wire [MW:0] step;
	wire [PW+1:0] sum;
	// Ratio is mult+4 edges per input period
	assign step = {1'b0, mult_in} + MULT_OFFSET;
	assign sum = acc + {{(PW+1-MW){1'b0}}, step};
	// Edges are spread over the measured input period; at most one edge per cycle,
	// so ratios above the period in cycles saturate (a limit of this clock rate).
	always @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			cnt <= {PW{1'b0}};
			period <= {PW{1'b0}};
			acc <= {(PW+2){1'b0}};
			stable <= 4'h0;
			tick_out <= 1'b0;
			locked_out <= 1'b0;
		end
		else if (ce_in)
		begin
			if (power_down_in)
			begin
				// Stop oscillating and drop lock
				cnt <= {PW{1'b0}};
				period <= {PW{1'b0}};
				acc <= {(PW+2){1'b0}};
				stable <= 4'h0;
				tick_out <= 1'b0;
				locked_out <= 1'b0;
			end
			else if (ref_tick_in)
			begin
				// Realign phase to every reference edge
				period <= cnt;
				cnt <= {{(PW-1){1'b0}}, 1'b1};
				acc <= {(PW+2){1'b0}};
				tick_out <= 1'b1;
				if (cnt == period && period != {PW{1'b0}})
				begin
					if (stable != LOCK_PERIODS[3:0])
						stable <= stable + 4'h1;
					else
						locked_out <= 1'b1;
				end
				else
				begin
					stable <= 4'h0;
					locked_out <= 1'b0;
				end
			end
			else
			begin
				if (cnt != {PW{1'b1}})
					cnt <= cnt + {{(PW-1){1'b0}}, 1'b1};
				if (period != {PW{1'b0}} && sum >= {2'b00, period})
				begin
					acc <= sum - {2'b00, period};
					tick_out <= 1'b1;
				end
				else
				begin
					acc <= sum;
					tick_out <= 1'b0;
				end
			end
		end
	end
endmodule

// ==== scg_clock_gen.v ====
// Notes on behaviour
// - Power-down bit set stops the loop and its output clock.
// - Loop path is never selected while the loop is powered down; the code stays on it if the divided loop level stops high.
// - Master stop bit halts the main clock for CPU and peripherals.
// - Wake pin, either external irq or RTC irq restarts stopped clock.
// - CPU gate bit gates CPU clock only on idle instruction.
// - Any unmasked interrupt restores the gated CPU clock.
// - Bypass drives main clock straight from selected reference.
// - Loop mode multiplies and divides, phase-locked to reference.
// - Path switch is glitch-free in both directions.
// - Multiplier ratio is field plus four, four to 4099.
// - Reference divider ratio four to 4099, skippable; in the code ratios 4097 to 4099 give the loop no input.
// - Output divider one to 128, skipped when not enabled; in the code an enabled divide by one holds the loop level high.
// - Output is ref times (mult+4) over enabled divider ratios.
// - Odd output divisor above one gives non-50 percent duty.
// - Clearing power-down starts the loop locking sequence.
// - Reset sets power-down and selects bypass.
// - Static reference strap: zero RTC, one clock pin.
//
// Local design decisions: the address map and the APB interface to the registers.
`timescale 1ns/10ps
`include "scg_regs.vh"
module scg_clock_gen #(
	parameter PW = 16,
	parameter MW = 12,
	parameter RW = 12,
	parameter OW = 7
) (
	input wire CLK_IN,
	input wire RST_B_IN,
	input wire CE_IN,
	input wire PSEL_IN,
	input wire PENABLE_IN,
	input wire PWRITE_IN,
	input wire [7:0] PADDR_IN,
	input wire [31:0] PWDATA_IN,
	output wire [31:0] PRDATA_OUT,
	output wire PREADY_OUT,
	output wire PSLVERR_OUT,
	input wire REF_CLOCK_PIN_IN,
	input wire RTC_OSC_IN,
	input wire REF_SELECT_IN,
	input wire WAKE_PIN_IN,
	input wire EXT_IRQ_A_IN,
	input wire EXT_IRQ_B_IN,
	input wire RTC_IRQ_IN,
	input wire CPU_IDLE_IN,
	input wire IRQ_UNMASKED_IN,
	output reg MAIN_SYS_CLOCK_OUT,
	output reg SYS_TICK_OUT,
	output reg CPU_CLOCK_OUT,
	output reg CPU_TICK_OUT,
	output reg LOOP_LOCKED_OUT
);
	localparam S_RUN = 3'b001;
	localparam S_DRAIN = 3'b010;
	localparam S_ARM = 3'b100;
	reg pll_power_down;
	reg [MW-1:0] mult;
	reg [RW-1:0] ref_div_ratio;
	reg ref_div_skip;
	reg [OW-1:0] out_div_ratio;
	reg out_div_on;
	reg pll_path_select;
	reg master_clock_stop;
	reg cpu_gate_reg;
	reg [2:0] ref_sync;
	reg [2:0] rtc_sync;
	reg [2:0] wake_sync;
	reg [2:0] irqa_sync;
	reg [2:0] irqb_sync;
	reg [2:0] rtci_sync;
	reg [2:0] strap_sync;
	reg ref_sel;
	reg strap_done;
	reg [1:0] strap_age;
	reg [RW-1:0] rd_cnt;
	reg loop_in_tick;
	reg [OW-1:0] od_cnt;
	reg pll_lvl;
	reg [2:0] state;
	reg cur_src;
	reg main_raw;
	reg stop_eff;
	reg cpu_gated;
	reg cpu_gate_eff;
	reg [31:0] rdata;
	wire pll_tick;
	wire dpll_locked;
	wire byp_tick;
	wire byp_lvl;
	wire want_src;
	wire cur_lvl;
	wire new_lvl;
	wire wake;
	wire wr;
	wire [RW:0] rd_limit;
	wire [OW:0] od_half;
	wire addr_ok;
	localparam [RW:0] RDR_OFFSET = `SCG_RDR_OFFSET;
	// Wake sources are rising edges seen on the free-running CLK_IN
	assign wake = (wake_sync[1] & ~wake_sync[2]) | (irqa_sync[1] & ~irqa_sync[2]) |
		(irqb_sync[1] & ~irqb_sync[2]) | (rtci_sync[1] & ~rtci_sync[2]);
	assign byp_lvl = ref_sel ? ref_sync[2] : rtc_sync[2];
	assign byp_tick = ref_sel ? (ref_sync[1] & ~ref_sync[2]) : (rtc_sync[1] & ~rtc_sync[2]);
	assign want_src = pll_path_select & ~pll_power_down;
	assign cur_lvl = cur_src ? pll_lvl : byp_lvl;
	assign new_lvl = want_src ? pll_lvl : byp_lvl;
	assign rd_limit = {1'b0, ref_div_ratio} + RDR_OFFSET;
	assign od_half = ({1'b0, out_div_ratio} + {{OW{1'b0}}, 1'b1}) >> 1;
	assign wr = PSEL_IN & PENABLE_IN & PWRITE_IN;
	assign addr_ok = (PADDR_IN == `SCG_OFF_GEN_CTRL1) || (PADDR_IN == `SCG_OFF_DIV_CTRL) ||
		(PADDR_IN == `SCG_OFF_CLK_CFG2) || (PADDR_IN == `SCG_OFF_PERIPH_GATE1) ||
		(PADDR_IN == `SCG_OFF_IDLE_CFG) || (PADDR_IN == `SCG_OFF_STATUS);
	assign PREADY_OUT = 1'b1;
	assign PSLVERR_OUT = PSEL_IN & PENABLE_IN & ~addr_ok;
	assign PRDATA_OUT = rdata;

	scg_dpll #(
		.PW(PW),
		.MW(MW),
		.LOCK_PERIODS(`SCG_LOCK_PERIODS)
	) scg_dpll_inst (
		.clk_in(CLK_IN),
		.rst_b_in(RST_B_IN),
		.ce_in(CE_IN),
		.power_down_in(pll_power_down),
		.ref_tick_in(loop_in_tick),
		.mult_in(mult),
		.tick_out(pll_tick),
		.locked_out(dpll_locked)
	);

	always @*
	begin
		rdata = 32'h0000_0000;
		case (PADDR_IN)
			`SCG_OFF_GEN_CTRL1:
			begin
				rdata[`SCG_BIT_PWRDN] = pll_power_down;
				rdata[`SCG_MULT_MSB:`SCG_MULT_LSB] = mult;
			end
			`SCG_OFF_DIV_CTRL:
			begin
				rdata[`SCG_RDR_MSB:`SCG_RDR_LSB] = ref_div_ratio;
				rdata[`SCG_BIT_RDSKIP] = ref_div_skip;
				rdata[`SCG_ODR_MSB:`SCG_ODR_LSB] = out_div_ratio;
				rdata[`SCG_BIT_ODON] = out_div_on;
			end
			`SCG_OFF_CLK_CFG2: rdata[`SCG_BIT_PATHSEL] = pll_path_select;
			`SCG_OFF_PERIPH_GATE1: rdata[`SCG_BIT_MSTOP] = master_clock_stop;
			`SCG_OFF_IDLE_CFG: rdata[`SCG_BIT_CPUGATE] = cpu_gate_reg;
			`SCG_OFF_STATUS: rdata[4:0] = {ref_sel, cpu_gated, stop_eff, LOOP_LOCKED_OUT, cur_src};
			default: rdata = 32'h0000_0000;
		endcase
	end

	// Register file; wake clears the stop bit and beats a same-cycle write
	always @(posedge CLK_IN or negedge RST_B_IN)
	begin
		if (!RST_B_IN)
		begin
			pll_power_down <= `SCG_RST_PWRDN;
			pll_path_select <= `SCG_RST_PATHSEL;
			mult <= `SCG_RST_MULT;
			ref_div_ratio <= `SCG_RST_RDR;
			ref_div_skip <= 1'b0;
			out_div_ratio <= `SCG_RST_ODR;
			out_div_on <= 1'b0;
			master_clock_stop <= 1'b0;
			cpu_gate_reg <= 1'b0;
		end
		else if (CE_IN)
		begin
			if (wr && PADDR_IN == `SCG_OFF_GEN_CTRL1)
			begin
				pll_power_down <= PWDATA_IN[`SCG_BIT_PWRDN];
				mult <= PWDATA_IN[`SCG_MULT_MSB:`SCG_MULT_LSB];
			end
			if (wr && PADDR_IN == `SCG_OFF_DIV_CTRL)
			begin
				ref_div_ratio <= PWDATA_IN[`SCG_RDR_MSB:`SCG_RDR_LSB];
				ref_div_skip <= PWDATA_IN[`SCG_BIT_RDSKIP];
				out_div_ratio <= PWDATA_IN[`SCG_ODR_MSB:`SCG_ODR_LSB];
				out_div_on <= PWDATA_IN[`SCG_BIT_ODON];
			end
			if (wr && PADDR_IN == `SCG_OFF_CLK_CFG2)
				pll_path_select <= PWDATA_IN[`SCG_BIT_PATHSEL];
			if (wake)
				master_clock_stop <= 1'b0;
			else if (wr && PADDR_IN == `SCG_OFF_PERIPH_GATE1)
				master_clock_stop <= PWDATA_IN[`SCG_BIT_MSTOP];
			if (wr && PADDR_IN == `SCG_OFF_IDLE_CFG)
				cpu_gate_reg <= PWDATA_IN[`SCG_BIT_CPUGATE];
		end
	end

	// Pin synchronisers; edges are judged on stages two and three only
	always @(posedge CLK_IN or negedge RST_B_IN)
	begin
		if (!RST_B_IN)
		begin
			ref_sync <= 3'h0;
			rtc_sync <= 3'h0;
			wake_sync <= 3'h0;
			irqa_sync <= 3'h0;
			irqb_sync <= 3'h0;
			rtci_sync <= 3'h0;
			strap_sync <= 3'h0;
			ref_sel <= 1'b0;
			strap_done <= 1'b0;
			strap_age <= 2'h0;
		end
		else if (CE_IN)
		begin
			ref_sync <= {ref_sync[1:0], REF_CLOCK_PIN_IN};
			rtc_sync <= {rtc_sync[1:0], RTC_OSC_IN};
			wake_sync <= {wake_sync[1:0], WAKE_PIN_IN};
			irqa_sync <= {irqa_sync[1:0], EXT_IRQ_A_IN};
			irqb_sync <= {irqb_sync[1:0], EXT_IRQ_B_IN};
			rtci_sync <= {rtci_sync[1:0], RTC_IRQ_IN};
			strap_sync <= {strap_sync[1:0], REF_SELECT_IN};
			// Strap is static; wait until stage three holds the pin, then catch it once
			if (strap_age != 2'h3)
				strap_age <= strap_age + 2'h1;
			else if (!strap_done && strap_sync[1] == strap_sync[2])
			begin
				ref_sel <= strap_sync[2];
				strap_done <= 1'b1;
			end
		end
	end

	// Reference divider and output divider around the loop
	always @(posedge CLK_IN or negedge RST_B_IN)
	begin
		if (!RST_B_IN)
		begin
			rd_cnt <= {RW{1'b0}};
			loop_in_tick <= 1'b0;
			od_cnt <= {OW{1'b0}};
			pll_lvl <= 1'b0;
			LOOP_LOCKED_OUT <= 1'b0;
		end
		else if (CE_IN)
		begin
			LOOP_LOCKED_OUT <= dpll_locked;
			loop_in_tick <= 1'b0;
			if (byp_tick)
			begin
				if (ref_div_skip)
					loop_in_tick <= 1'b1;
				else if ({1'b0, rd_cnt} + {{RW{1'b0}}, 1'b1} >= rd_limit)
				begin
					rd_cnt <= {RW{1'b0}};
					loop_in_tick <= 1'b1;
				end
				else
					rd_cnt <= rd_cnt + {{(RW-1){1'b0}}, 1'b1};
			end
			if (!out_div_on)
			begin
				od_cnt <= {OW{1'b0}};
				pll_lvl <= pll_tick;
			end
			else if (pll_tick)
			begin
				// High for the first half rounded down: odd ratios skew duty
				if (od_cnt >= out_div_ratio)
				begin
					od_cnt <= {OW{1'b0}};
					pll_lvl <= 1'b1;
				end
				else
				begin
					od_cnt <= od_cnt + {{(OW-1){1'b0}}, 1'b1};
					pll_lvl <= ({1'b0, od_cnt} + {{OW{1'b0}}, 1'b1}) < od_half;
				end
			end
		end
	end

	// Path mux: leave old source only while low, join new one only while low
	always @(posedge CLK_IN or negedge RST_B_IN)
	begin
		if (!RST_B_IN)
		begin
			state <= S_RUN;
			cur_src <= 1'b0;
			main_raw <= 1'b0;
		end
		else if (CE_IN)
		begin
			case (state)
				S_RUN:
				begin
					main_raw <= cur_lvl;
					if (want_src != cur_src && !cur_lvl)
					begin
						state <= S_DRAIN;
						main_raw <= 1'b0;
					end
				end
				S_DRAIN:
				begin
					main_raw <= 1'b0;
					if (!new_lvl)
					begin
						cur_src <= want_src;
						state <= S_ARM;
					end
				end
				S_ARM:
				begin
					main_raw <= 1'b0;
					state <= S_RUN;
				end
				default:
				begin
					state <= S_RUN;
					main_raw <= 1'b0;
				end
			endcase
		end
	end

	// Stop and CPU gating change only while the raw clock is low
	always @(posedge CLK_IN or negedge RST_B_IN)
	begin
		if (!RST_B_IN)
		begin
			stop_eff <= 1'b0;
			cpu_gated <= 1'b0;
			cpu_gate_eff <= 1'b0;
			MAIN_SYS_CLOCK_OUT <= 1'b0;
			SYS_TICK_OUT <= 1'b0;
			CPU_CLOCK_OUT <= 1'b0;
			CPU_TICK_OUT <= 1'b0;
		end
		else if (CE_IN)
		begin
			// An interrupt wins over an idle in the same cycle
			if (IRQ_UNMASKED_IN)
				cpu_gated <= 1'b0;
			else if (CPU_IDLE_IN && cpu_gate_reg)
				cpu_gated <= 1'b1;
			if (!main_raw)
			begin
				stop_eff <= master_clock_stop & ~wake;
				cpu_gate_eff <= cpu_gated & ~IRQ_UNMASKED_IN;
			end
			MAIN_SYS_CLOCK_OUT <= main_raw & ~stop_eff;
			SYS_TICK_OUT <= main_raw & ~stop_eff & ~MAIN_SYS_CLOCK_OUT;
			CPU_CLOCK_OUT <= main_raw & ~stop_eff & ~cpu_gate_eff;
			CPU_TICK_OUT <= main_raw & ~stop_eff & ~cpu_gate_eff & ~CPU_CLOCK_OUT;
		end
	end
endmodule

// ==== scg_clock_gen_props.sv ====
`timescale 1ns/10ps
module scg_clock_gen_props (
	input wire CLK_IN,
	input wire RST_B_IN,
	input wire PSEL_IN,
	input wire PENABLE_IN,
	input wire PWRITE_IN,
	input wire [7:0] PADDR_IN,
	input wire [31:0] PWDATA_IN,
	input wire [31:0] PRDATA_OUT,
	input wire PREADY_OUT,
	input wire PSLVERR_OUT,
	input wire WAKE_PIN_IN,
	input wire IRQ_UNMASKED_IN,
	input wire SYS_TICK_OUT,
	input wire CPU_TICK_OUT,
	input wire MAIN_SYS_CLOCK_OUT,
	input wire LOOP_LOCKED_OUT
);
	default clocking @(posedge CLK_IN); endclocking
	default disable iff (!RST_B_IN);
	wire acc = PSEL_IN && PENABLE_IN;
	wire wr_set = acc && PWRITE_IN && PWDATA_IN[0];
	// Windows cover one slow reference period plus sync and mux latency
	ready_zero_wait_a: assert property (acc |-> PREADY_OUT) else $error("pready low in access");
	unmapped_err_a: assert property (acc && PADDR_IN > 8'h14 |-> PSLVERR_OUT && PRDATA_OUT == 32'h0)
		else $error("unmapped access not refused");
	mapped_ok_a: assert property (acc && PADDR_IN <= 8'h14 && PADDR_IN[1:0] == 2'h0 |-> !PSLVERR_OUT)
		else $error("mapped access refused");
	reset_quiet_a: assert property ($rose(RST_B_IN) |-> !MAIN_SYS_CLOCK_OUT && !LOOP_LOCKED_OUT)
		else $error("outputs active after reset");
	pwrdn_unlock_a: assert property (wr_set && PADDR_IN == 8'h00 |-> ##[1:4] !LOOP_LOCKED_OUT)
		else $error("loop still locked after power down");
	stop_halts_a: assert property (wr_set && PADDR_IN == 8'h0c |-> ##[1:20] (!SYS_TICK_OUT)[*8])
		else $error("main clock kept running after stop");
	wake_restart_a: assert property ($rose(WAKE_PIN_IN) |-> ##[1:40] SYS_TICK_OUT)
		else $error("wake did not restart main clock");
	irq_restore_a: assert property ($rose(IRQ_UNMASKED_IN) |-> ##[1:30] CPU_TICK_OUT)
		else $error("interrupt did not restore cpu clock");
	cpu_in_main_a: assert property (CPU_TICK_OUT |-> SYS_TICK_OUT || $past(SYS_TICK_OUT))
		else $error("cpu tick without main tick");
endmodule
bind scg_clock_gen scg_clock_gen_props scg_clock_gen_props_inst (.CLK_IN(CLK_IN), .RST_B_IN(RST_B_IN),
	.PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN),
	.PWDATA_IN(PWDATA_IN), .PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT),
	.PSLVERR_OUT(PSLVERR_OUT), .WAKE_PIN_IN(WAKE_PIN_IN), .IRQ_UNMASKED_IN(IRQ_UNMASKED_IN),
	.SYS_TICK_OUT(SYS_TICK_OUT), .CPU_TICK_OUT(CPU_TICK_OUT),
	.MAIN_SYS_CLOCK_OUT(MAIN_SYS_CLOCK_OUT), .LOOP_LOCKED_OUT(LOOP_LOCKED_OUT));

// ==== scg_clock_gen_tb_top.sv ====
`timescale 1ns/10ps
module scg_clock_gen_tb_top;
	logic CLK_IN = 1'b0;
	logic RST_B_IN = 1'b0;
	logic PSEL_IN = 1'b0;
	logic PENABLE_IN = 1'b0;
	logic PWRITE_IN = 1'b0;
	logic [7:0] PADDR_IN = 8'h00;
	logic [31:0] PWDATA_IN = 32'h0;
	logic [3:0] wake = 4'h0;
	logic [3:0] ph = 4'h0;
	logic CPU_IDLE_IN = 1'b0;
	logic IRQ_UNMASKED_IN = 1'b0;
	logic CE_IN = 1'b1;
	logic REF_SELECT_IN = 1'b1;
	wire [31:0] PRDATA_OUT;
	wire PREADY_OUT, PSLVERR_OUT, MAIN_SYS_CLOCK_OUT, SYS_TICK_OUT;
	wire CPU_CLOCK_OUT, CPU_TICK_OUT, LOOP_LOCKED_OUT;
	logic [31:0] rst_val [6] = '{32'h1, 32'h0, 32'h0, 32'h0, 32'h0, 32'h10};
	int err_count = 0;
	int n_checks = 0;
	int cycles = 0;
	int s;
	int c;
	logic [31:0] q;
	logic e;
	scg_clock_gen scg_clock_gen_inst (.CLK_IN(CLK_IN), .RST_B_IN(RST_B_IN), .CE_IN(CE_IN),
		.PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN),
		.PWDATA_IN(PWDATA_IN), .PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT),
		.PSLVERR_OUT(PSLVERR_OUT), .REF_CLOCK_PIN_IN(ph[2]), .RTC_OSC_IN(ph[3]),
		.REF_SELECT_IN(REF_SELECT_IN), .WAKE_PIN_IN(wake[0]), .EXT_IRQ_A_IN(wake[1]),
		.EXT_IRQ_B_IN(wake[2]), .RTC_IRQ_IN(wake[3]), .CPU_IDLE_IN(CPU_IDLE_IN),
		.IRQ_UNMASKED_IN(IRQ_UNMASKED_IN), .MAIN_SYS_CLOCK_OUT(MAIN_SYS_CLOCK_OUT),
		.SYS_TICK_OUT(SYS_TICK_OUT), .CPU_CLOCK_OUT(CPU_CLOCK_OUT),
		.CPU_TICK_OUT(CPU_TICK_OUT), .LOOP_LOCKED_OUT(LOOP_LOCKED_OUT));
	always #5 CLK_IN = ~CLK_IN;
	// Pin reference has period 8 cycles, slow oscillator 16, so the strap choice shows in counts
	always @(posedge CLK_IN)
	begin
		ph <= ph + 4'h1;
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			err_count++;
			tally_and_finish();
		end
	end
	task tally_and_finish;
	begin
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	end
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
	begin
		n_checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	end
	endtask
	// Idle cycle after each transfer keeps one assignment per signal per step
	// Waits for ready as long as it takes; only the bench timeout ends a hang
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
	begin
		PSEL_IN <= 1'b1;
		PWRITE_IN <= w;
		PADDR_IN <= a;
		PWDATA_IN <= d;
		@(posedge CLK_IN);
		PENABLE_IN <= 1'b1;
		do
		begin
			@(posedge CLK_IN);
		end
		while (PREADY_OUT !== 1'b1);
		q = PRDATA_OUT;
		e = PSLVERR_OUT;
		PSEL_IN <= 1'b0;
		PENABLE_IN <= 1'b0;
		@(posedge CLK_IN);
	end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
	begin
		apb(1'b0, a, 32'h0);
		chk(q, exp);
	end
	endtask
	task automatic cnt(input int n);
	begin
		s = 0;
		c = 0;
		repeat (n)
		begin
			@(posedge CLK_IN);
			if (SYS_TICK_OUT === 1'b1)
				s++;
			if (CPU_TICK_OUT === 1'b1)
				c++;
		end
	end
	endtask
	task automatic idle_pulse;
	begin
		CPU_IDLE_IN <= 1'b1;
		@(posedge CLK_IN);
		CPU_IDLE_IN <= 1'b0;
		repeat (20) @(posedge CLK_IN);
		cnt(80);
	end
	endtask
	initial
	begin
		repeat (16) @(posedge CLK_IN);
		RST_B_IN <= 1'b1;
		@(posedge CLK_IN);
		for (int i = 0; i < 6; i++)
			rd(8'(4 * i), rst_val[i]);
		wr(8'h04, 32'h00ff_1fff);
		rd(8'h04, 32'h00ff_1fff);
		wr(8'h00, 32'h0fff_0001);
		rd(8'h00, 32'h0fff_0001);
		apb(1'b1, 8'h18, 32'hffff_ffff);
		chk({31'h0, e}, 32'h1);
		rd(8'h18, 32'h0);
		chk({31'h0, e}, 32'h1);
		wr(8'h08, 32'h1);
		rd(8'h14, 32'h10);
		cnt(160);
		chk(s, 32'd20);
		$display("test registers done");
		wr(8'h08, 32'h0);
		wr(8'h04, 32'h0081_1000);
		wr(8'h00, 32'h0);
		repeat (400) if (LOOP_LOCKED_OUT !== 1'b1) @(posedge CLK_IN);
		chk({31'h0, LOOP_LOCKED_OUT}, 32'h1);
		wr(8'h08, 32'h1);
		repeat (60) @(posedge CLK_IN);
		rd(8'h14, 32'h13);
		cnt(160);
		chk(s, 32'd40);
		wr(8'h08, 32'h0);
		repeat (40) @(posedge CLK_IN);
		cnt(160);
		chk(s, 32'd20);
		wr(8'h00, 32'h1);
		rd(8'h14, 32'h10);
		$display("test loop done");
		for (int i = 0; i < 4; i++)
		begin
			wr(8'h0c, 32'h1);
			repeat (30) @(posedge CLK_IN);
			cnt(80);
			chk(s, 32'd0);
			chk({31'h0, MAIN_SYS_CLOCK_OUT}, 32'h0);
			rd(8'h14, 32'h14);
			wake[i] <= 1'b1;
			repeat (4) @(posedge CLK_IN);
			wake[i] <= 1'b0;
			repeat (30) @(posedge CLK_IN);
			rd(8'h0c, 32'h0);
			cnt(80);
			chk(s, 32'd10);
		end
		$display("test stop done");
		idle_pulse();
		chk(c, 32'd10);
		wr(8'h10, 32'h1);
		cnt(80);
		chk(c, 32'd10);
		idle_pulse();
		chk(c, 32'd0);
		chk({31'h0, CPU_CLOCK_OUT}, 32'h0);
		chk(s, 32'd10);
		rd(8'h14, 32'h18);
		IRQ_UNMASKED_IN <= 1'b1;
		repeat (2) @(posedge CLK_IN);
		IRQ_UNMASKED_IN <= 1'b0;
		repeat (20) @(posedge CLK_IN);
		cnt(80);
		chk(c, 32'd10);
		$display("test cpu gate done");
		// A write while the enable is low must be ignored
		CE_IN <= 1'b0;
		wr(8'h10, 32'h0);
		CE_IN <= 1'b1;
		rd(8'h10, 32'h1);
		// Mid-run reset with the strap on the slow oscillator
		RST_B_IN <= 1'b0;
		REF_SELECT_IN <= 1'b0;
		repeat (4) @(posedge CLK_IN);
		RST_B_IN <= 1'b1;
		repeat (8) @(posedge CLK_IN);
		rd(8'h00, 32'h1);
		rd(8'h14, 32'h0);
		cnt(160);
		chk(s, 32'd10);
		$display("test enable and strap done");
		tally_and_finish();
	end
endmodule
